// >>> src/clk_synth_pkg.sv
// Package: register map, field layout, reset values and constants
package clk_synth_pkg;
  // Register byte offsets
  localparam logic [11:0] OUTPUT_FORMAT_CONFIG_ADDR = 12'h000;
  localparam logic [11:0] MASTER_CONFIG_FOUR_ADDR = 12'h004;
  localparam logic [11:0] MASTER_CONFIG_SIX_ADDR = 12'h008;
  localparam logic [11:0] MASTER_CONFIG_SEVEN_ADDR = 12'h00C;
  localparam logic [11:0] SYNC_CONFIG_ONE_ADDR = 12'h010;
  localparam logic [11:0] SYNC_CONFIG_TWO_ADDR = 12'h014;
  localparam logic [11:0] PRIMARY_LOOP_CONFIG_ADDR = 12'h018;
  localparam logic [11:0] SECONDARY_LOOP_CONFIG_ADDR = 12'h01C;
  localparam logic [11:0] FREQ_WORD_BASE_ADDR = 12'h020;
  localparam logic [11:0] PHASE_OFFSET_ADDR = 12'h040;
  localparam logic [11:0] SOURCE_STATUS_ADDR = 12'h044;
  localparam int NUM_FREQ_WORDS = 8;
  // Field positions
  localparam int LOCK_ALL_BIT = 0;
  localparam int DIG_A_FAMILY_BIT = 0;
  localparam int DIG_B_FAMILY_BIT = 1;
  localparam int DIG_B_ALT_BIT = 2;
  localparam int DIG_A_MULT_LSB = 0;
  localparam int DIG_B_MULT_LSB = 2;
  localparam int DIG_A_SRC_BIT = 4;
  localparam int DIG_B_SRC_BIT = 5;
  localparam int LOW_RATE_SRC_BIT = 0;
  localparam int FS_POL_BIT = 16;
  localparam int MFS_POL_BIT = 17;
  localparam int INDEPENDENT_SYNC_MODE_BIT = 0;
  localparam int SEC_TO_PRI_BIT = 0;
  // Pulse widths in master clock cycles, reset values
  localparam logic [7:0] FS_WIDTH_RESET = 8'h01;
  localparam logic [7:0] MFS_WIDTH_RESET = 8'h01;
  localparam logic [31:0] FORMAT_RESET = 32'h0000_0000;
  // Clock and sync timing
  localparam int CLOCK_HZ = 20_000_000;
  localparam int FRAME_HZ = 8_000;
  localparam int MFRAME_HZ = 2_000;
  localparam int FRAME_CYCLES = CLOCK_HZ / FRAME_HZ;
  localparam int MFRAME_PER_FRAME = FRAME_HZ / MFRAME_HZ;
  // Differential output formats
  typedef enum logic [1:0]
  {
    FMT_DISABLED = 2'b00,
    FMT_LVDS = 2'b01,
    FMT_LVPECL = 2'b10,
    FMT_RESERVED = 2'b11
  } diff_format_e;
  // Synthesis block index
  localparam int NUM_SYNTH = 7;
  localparam int SYN_LOW_RATE = 0;
  localparam int SYN_FRAME = 1;
  localparam int SYN_DIG_A = 2;
  localparam int SYN_DIG_B = 3;
  localparam int SYN_APLL_PRI = 4;
  localparam int SYN_APLL_PRI2 = 5;
  localparam int SYN_APLL_SEC = 6;
  typedef struct packed
  {
    logic paddr_ok;
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed
  {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
endpackage

// >>> src/output_clock_synth_routing.sv
// Module: output clock synthesis, routing, sync pulses and config registers
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module output_clock_synth_routing
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] primary_loop_freq,
  input wire logic [31:0] secondary_loop_freq,
  output logic primary_feedback_clk,
  output logic secondary_feedback_clk,
  output logic [6:0] general_output,
  output logic [3:0] diff_output,
  output logic [3:0] diff_output_on,
  output logic frame_sync_out,
  output logic multiframe_sync_out,
  output logic secondary_apll_power_on
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [31:0] output_format_config;
    logic [31:0] master_config_four;
    logic [31:0] master_config_six;
    logic [31:0] master_config_seven;
    logic [31:0] sync_config_one;
    logic [31:0] sync_config_two;
    logic [31:0] primary_loop_config;
    logic [31:0] secondary_loop_config;
    logic [31:0] phase_offset;
    logic [7:0][31:0] freq_word;
    logic [15:0] frame_count;
    logic [1:0] mframe_count;
    logic [7:0] fs_width_count;
    logic [7:0] mfs_width_count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [6:0] general_output;
    logic [3:0] diff_output;
    logic [3:0] diff_output_on;
    logic [3:0][1:0] diff_format;
    logic frame_sync;
    logic multiframe_sync;
    logic apll_power;
  } state_s;
  state_s state_reg;
  state_s state_next;

  logic [31:0] synth_inc [clk_synth_pkg::NUM_SYNTH];
  logic [6:0] synth_clk;
  logic [6:0] synth_src_sec;
  logic primary_fwd_clk;
  logic secondary_fwd_clk;
  logic [31:0] primary_fwd_phase;
  logic [31:0] secondary_fwd_phase;
  logic lock_all;
  logic apll_sec_off;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Scale a loop increment by a digital-rate multiplier of 1, 2, 4 or 8
  function automatic logic [31:0] rate_scale(input logic [31:0] base,
    input logic [1:0] mult);
    return base << mult;
  endfunction

  // ----------------------------------------------------------------
  // Source routing
  // ----------------------------------------------------------------
  assign lock_all =
    state_reg.master_config_four[clk_synth_pkg::LOCK_ALL_BIT];
  assign apll_sec_off =
    (state_reg.secondary_loop_config[3:0] == 4'h0) &&
    !state_reg.primary_loop_config[clk_synth_pkg::SEC_TO_PRI_BIT];

  always_comb
  begin
    synth_src_sec = '0;
    synth_src_sec[clk_synth_pkg::SYN_LOW_RATE] = !lock_all &&
      state_reg.sync_config_one[clk_synth_pkg::LOW_RATE_SRC_BIT];
    synth_src_sec[clk_synth_pkg::SYN_FRAME] =
      state_reg.sync_config_two[clk_synth_pkg::INDEPENDENT_SYNC_MODE_BIT] && !lock_all;
    synth_src_sec[clk_synth_pkg::SYN_DIG_A] = !lock_all &&
      state_reg.master_config_seven[clk_synth_pkg::DIG_A_SRC_BIT];
    synth_src_sec[clk_synth_pkg::SYN_DIG_B] = !lock_all &&
      state_reg.master_config_seven[clk_synth_pkg::DIG_B_SRC_BIT];
    synth_src_sec[clk_synth_pkg::SYN_APLL_SEC] = !lock_all &&
      !state_reg.primary_loop_config[clk_synth_pkg::SEC_TO_PRI_BIT];
    // Primary APLL references stay at zero, fixed to primary loop
  end

  // Increments: loop frequency plus the software frequency word
  always_comb
  begin
    for (int i = 0; i < clk_synth_pkg::NUM_SYNTH; i++)
    begin
      synth_inc[i] = (synth_src_sec[i] ? secondary_loop_freq :
        primary_loop_freq) + state_reg.freq_word[i];
    end
    synth_inc[clk_synth_pkg::SYN_DIG_A] = rate_scale(
      synth_inc[clk_synth_pkg::SYN_DIG_A] >>
      state_reg.master_config_six[clk_synth_pkg::DIG_A_FAMILY_BIT],
      state_reg.master_config_seven[clk_synth_pkg::DIG_A_MULT_LSB +: 2]);
    synth_inc[clk_synth_pkg::SYN_DIG_B] =
      state_reg.master_config_six[clk_synth_pkg::DIG_B_ALT_BIT] ?
      synth_inc[clk_synth_pkg::SYN_DIG_B] + state_reg.freq_word[7] :
      rate_scale(synth_inc[clk_synth_pkg::SYN_DIG_B] >>
      state_reg.master_config_six[clk_synth_pkg::DIG_B_FAMILY_BIT],
      state_reg.master_config_seven[clk_synth_pkg::DIG_B_MULT_LSB +: 2]);
  end

  // ----------------------------------------------------------------
  // Synthesis blocks
  // ----------------------------------------------------------------
  phase_accum primary_fwd
  (
    .clock(clock), .rst(rst), .enable(1'b1), .increment(primary_loop_freq),
    .offset(32'h0000_0000), .phase(primary_fwd_phase),
    .clk_out(primary_fwd_clk)
  );

  // Feedback copy tied to the forward word; offset only shifts phase
  phase_accum primary_fb
  (
    .clock(clock), .rst(rst), .enable(1'b1), .increment(primary_loop_freq),
    .offset(state_reg.phase_offset), .phase(),
    .clk_out(primary_feedback_clk)
  );

  // Secondary loop uses its one forward synth for feedback too
  phase_accum secondary_fwd
  (
    .clock(clock), .rst(rst), .enable(1'b1), .increment(secondary_loop_freq),
    .offset(32'h0000_0000), .phase(secondary_fwd_phase),
    .clk_out(secondary_fwd_clk)
  );
  assign secondary_feedback_clk = secondary_fwd_clk;

  genvar g;
  generate
    for (g = 0; g < clk_synth_pkg::NUM_SYNTH; g++)
    begin : gen_synth
      phase_accum out_synth
      (
        .clock(clock), .rst(rst),
        .enable(!(g == clk_synth_pkg::SYN_APLL_SEC && apll_sec_off)),
        .increment(synth_inc[g]), .offset(32'h0000_0000), .phase(),
        .clk_out(synth_clk[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] rd;
    logic hit;
    logic [7:0] fs_w;
    logic [7:0] mfs_w;
    rd = 32'h0000_0000;
    hit = 1'b1;
    state_next = state_reg;
    fs_w = state_reg.sync_config_one[15:8];
    mfs_w = state_reg.sync_config_two[15:8];
    // APB: answer one cycle into the access phase
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    case (paddr)
      clk_synth_pkg::OUTPUT_FORMAT_CONFIG_ADDR:
        rd = state_reg.output_format_config;
      clk_synth_pkg::MASTER_CONFIG_FOUR_ADDR: rd = state_reg.master_config_four;
      clk_synth_pkg::MASTER_CONFIG_SIX_ADDR: rd = state_reg.master_config_six;
      clk_synth_pkg::MASTER_CONFIG_SEVEN_ADDR:
        rd = state_reg.master_config_seven;
      clk_synth_pkg::SYNC_CONFIG_ONE_ADDR: rd = state_reg.sync_config_one;
      clk_synth_pkg::SYNC_CONFIG_TWO_ADDR: rd = state_reg.sync_config_two;
      clk_synth_pkg::PRIMARY_LOOP_CONFIG_ADDR:
        rd = state_reg.primary_loop_config;
      clk_synth_pkg::SECONDARY_LOOP_CONFIG_ADDR:
        rd = state_reg.secondary_loop_config;
      clk_synth_pkg::PHASE_OFFSET_ADDR: rd = state_reg.phase_offset;
      clk_synth_pkg::SOURCE_STATUS_ADDR:
        rd = {16'h0000, 1'b0, synth_src_sec, 7'h00, state_reg.apll_power};
      default:
      begin
        if (paddr[11:5] == clk_synth_pkg::FREQ_WORD_BASE_ADDR[11:5] &&
          paddr[1:0] == 2'b00)
        begin
          rd = state_reg.freq_word[paddr[4:2]];
        end
        else
        begin
          hit = 1'b0;
        end
      end
    endcase
    if (psel && penable && !state_reg.pready)
    begin
      state_next.pready = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata = pwrite ? 32'h0000_0000 : (hit ? rd : 32'h0000_0000);
    end
    if (psel && penable && state_reg.pready && pwrite && hit)
    begin
      case (paddr)
        clk_synth_pkg::OUTPUT_FORMAT_CONFIG_ADDR:
          state_next.output_format_config = merge_bytes(
            state_reg.output_format_config, pwdata, pstrb);
        clk_synth_pkg::MASTER_CONFIG_FOUR_ADDR:
          state_next.master_config_four = merge_bytes(
            state_reg.master_config_four, pwdata, pstrb);
        clk_synth_pkg::MASTER_CONFIG_SIX_ADDR:
          state_next.master_config_six = merge_bytes(
            state_reg.master_config_six, pwdata, pstrb);
        clk_synth_pkg::MASTER_CONFIG_SEVEN_ADDR:
          state_next.master_config_seven = merge_bytes(
            state_reg.master_config_seven, pwdata, pstrb);
        clk_synth_pkg::SYNC_CONFIG_ONE_ADDR:
          state_next.sync_config_one = merge_bytes(
            state_reg.sync_config_one, pwdata, pstrb);
        clk_synth_pkg::SYNC_CONFIG_TWO_ADDR:
          state_next.sync_config_two = merge_bytes(
            state_reg.sync_config_two, pwdata, pstrb);
        clk_synth_pkg::PRIMARY_LOOP_CONFIG_ADDR:
          state_next.primary_loop_config = merge_bytes(
            state_reg.primary_loop_config, pwdata, pstrb);
        clk_synth_pkg::SECONDARY_LOOP_CONFIG_ADDR:
          state_next.secondary_loop_config = merge_bytes(
            state_reg.secondary_loop_config, pwdata, pstrb);
        clk_synth_pkg::PHASE_OFFSET_ADDR:
          state_next.phase_offset = merge_bytes(
            state_reg.phase_offset, pwdata, pstrb);
        clk_synth_pkg::SOURCE_STATUS_ADDR:
          state_next.phase_offset = state_reg.phase_offset;
        default:
          state_next.freq_word[paddr[4:2]] = merge_bytes(
            state_reg.freq_word[paddr[4:2]], pwdata, pstrb);
      endcase
    end
    // ----------------------------------------------------------------
    // Frame and multiframe sync
    // ----------------------------------------------------------------
    // Timebase counts master cycles; independent mode only changes source
    if (state_reg.frame_count == 16'(clk_synth_pkg::FRAME_CYCLES - 1))
    begin
      state_next.frame_count = 16'h0000;
      state_next.mframe_count = state_reg.mframe_count + 2'h1;
      state_next.fs_width_count = (fs_w == 8'h00) ? 8'h01 : fs_w;
      if (state_reg.mframe_count == 2'h3)
      begin
        state_next.mfs_width_count = (mfs_w == 8'h00) ? 8'h01 : mfs_w;
      end
    end
    else
    begin
      state_next.frame_count = state_reg.frame_count + 16'h0001;
      if (state_reg.fs_width_count != 8'h00)
      begin
        state_next.fs_width_count = state_reg.fs_width_count - 8'h01;
      end
      if (state_reg.mfs_width_count != 8'h00)
      begin
        state_next.mfs_width_count = state_reg.mfs_width_count - 8'h01;
      end
    end
    state_next.frame_sync = (state_reg.fs_width_count != 8'h00) ^
      state_reg.sync_config_one[clk_synth_pkg::FS_POL_BIT];
    state_next.multiframe_sync = (state_reg.mfs_width_count != 8'h00) ^
      state_reg.sync_config_one[clk_synth_pkg::MFS_POL_BIT];
    // ----------------------------------------------------------------
    // Output mapping
    // ----------------------------------------------------------------
    state_next.apll_power = !apll_sec_off;
    for (int k = 0; k < 7; k++)
    begin
      state_next.general_output[k] = synth_clk[k];
    end
    if (apll_sec_off)
    begin
      state_next.general_output[clk_synth_pkg::SYN_APLL_SEC] = 1'b0;
    end
    for (int d = 0; d < 4; d++)
    begin
      // Format is only taken while the line is low, so switching an output off leaves no runt
      if (!state_reg.diff_output[d])
      begin
        state_next.diff_format[d] =
          state_reg.output_format_config[d*2 +: 2];
      end
      state_next.diff_output_on[d] =
        state_next.diff_format[d] != clk_synth_pkg::FMT_DISABLED;
      state_next.diff_output[d] = state_next.diff_output_on[d] &&
        state_next.general_output[d + 3];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.sync_config_one[15:8] <= clk_synth_pkg::FS_WIDTH_RESET;
      state_reg.sync_config_two[15:8] <= clk_synth_pkg::MFS_WIDTH_RESET;
      state_reg.output_format_config <= clk_synth_pkg::FORMAT_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign general_output = state_reg.general_output;
  assign diff_output = state_reg.diff_output;
  assign diff_output_on = state_reg.diff_output_on;
  assign frame_sync_out = state_reg.frame_sync;
  assign multiframe_sync_out = state_reg.multiframe_sync;
  assign secondary_apll_power_on = state_reg.apll_power;
endmodule
`default_nettype wire

// >>> src/phase_accum.sv
// Module: one phase-accumulator synthesis block
`timescale 1ns/1ps
`default_nettype none
module phase_accum
(
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [31:0] increment,
  input wire logic [31:0] offset,
  output logic [31:0] phase,
  output logic clk_out
);
  typedef struct packed
  {
    logic [31:0] acc;
    logic [31:0] phase;
    logic clk;
  } state_s;
  state_s state_reg;
  state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (enable)
    begin
      state_next.acc = state_reg.acc + increment;
    end
    state_next.phase = state_reg.acc + offset;
    state_next.clk = enable & state_next.phase[31];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign phase = state_reg.phase;
  assign clk_out = state_reg.clk;
endmodule
`default_nettype wire

// >>> verif/loop_source.sv
// Partner: loop increment words seen by the synthesis stage
`timescale 1ns/1ps
`default_nettype none
module loop_source
#(
  parameter logic [31:0] PRI_WORD = 32'h2000_0000,
  parameter logic [31:0] SEC_WORD = 32'h1000_0000
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  output logic [31:0] primary_loop_freq,
  output logic [31:0] secondary_loop_freq
);
  // --------------------------------
  // Words move only on a clock edge
  // --------------------------------
  // Slow mode halves the primary word, as a loop pulling in would
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      primary_loop_freq <= PRI_WORD;
      secondary_loop_freq <= SEC_WORD;
    end
    else
    begin
      primary_loop_freq <= slow ? PRI_WORD >> 1 : PRI_WORD;
      secondary_loop_freq <= SEC_WORD;
    end
  end
endmodule
`default_nettype wire

// >>> verif/output_clock_synth_routing_bench.sv
// Bench: directed scenarios for the output clock synthesis block
`timescale 1ns/1ps
`default_nettype none
module output_clock_synth_routing_bench;
  logic clock, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, inv = 1'b0, pready, pslverr, primary_feedback_clk;
  logic secondary_feedback_clk, frame_sync_out, multiframe_sync_out;
  logic secondary_apll_power_on;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, primary_loop_freq, secondary_loop_freq;
  logic [3:0] pstrb = 4'hF, diff_output, diff_output_on;
  logic [6:0] general_output;
  int bad_count = 0, checks = 0;
  // --------------------------------
  // Clock and instances
  // --------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  output_clock_synth_routing dut
  (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_loop_freq(primary_loop_freq),
    .secondary_loop_freq(secondary_loop_freq),
    .primary_feedback_clk(primary_feedback_clk),
    .secondary_feedback_clk(secondary_feedback_clk),
    .general_output(general_output), .diff_output(diff_output),
    .diff_output_on(diff_output_on), .frame_sync_out(frame_sync_out),
    .multiframe_sync_out(multiframe_sync_out),
    .secondary_apll_power_on(secondary_apll_power_on)
  );
  loop_source far
  (
    .clock(clock), .rst(rst), .slow(slow),
    .primary_loop_freq(primary_loop_freq),
    .secondary_loop_freq(secondary_loop_freq)
  );
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim)
    begin
      bad_count++;
      $display("Error wait ran out");
      final_report();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
    hang(n, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // Reads one register and compares the bits under the mask
  task automatic rd(input string what, input logic [11:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, exp, r & m);
  endtask
  function automatic logic syn(input logic mf);
    return (mf ? multiframe_sync_out : frame_sync_out) ^ inv;
  endfunction
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd("format", 12'h000, 32'hFFFF_FFFF, clk_synth_pkg::FORMAT_RESET);
    rd("fs width", 12'h010, 32'h0000_FF00, 32'h0000_0100);
    rd("mfs width", 12'h014, 32'h0000_FF00, 32'h0000_0100);
    pstrb <= 4'h1;
    wr(12'h010, 32'h0000_0700);
    pstrb <= 4'hF;
    rd("masked byte", 12'h010, 32'h0000_FF00, 32'h0000_0100);
    wr(12'h020, 32'h0000_1000);
    rd("freq word", 12'h020, 32'hFFFF_FFFF, 32'h0000_1000);
    apb(1'b0, 12'h0F0, 32'h0, r, e);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
    $display("t_regs done");
  endtask
  // Times one pulse from its leading edge; inv folds in a set polarity
  task automatic t_sync(input logic mf, input int hi_exp, input int per_exp);
    int i, j, hi, per;
    for (i = 0; i < 30000 && syn(mf) !== 1'b0; i++) @(posedge clock);
    for (j = 0; j < 30000 && syn(mf) !== 1'b1; j++) @(posedge clock);
    hang(i > j ? i : j, 30000);
    for (hi = 0; hi < 300 && syn(mf) === 1'b1; hi++) @(posedge clock);
    for (per = hi; per < 30000 && syn(mf) !== 1'b1; per++) @(posedge clock);
    hang(per, 30000);
    check("sync width", hi_exp, hi);
    check("sync period", per_exp, per);
    $display("t_sync done");
  endtask
  task automatic t_src;
    rd("status rst", 12'h044, 32'h0000_7F01,
      32'h0000_4000);
    check("apll power", 32'h0, {31'h0, secondary_apll_power_on});
    wr(12'h00C, 32'h0000_0030);
    wr(12'h010, 32'h0000_0101);
    wr(12'h014, 32'h0000_0101);
    rd("sources", 12'h044, 32'h0000_7F00,
      32'h0000_4F00);
    wr(12'h004, 32'h0000_0001);
    rd("lock all", 12'h044, 32'h0000_7F00, 32'h0000_0000);
    wr(12'h004, 32'h0000_0000);
    wr(12'h018, 32'h0000_0001);
    rd("to primary", 12'h044, 32'h0000_7F01, 32'h0000_0F01);
    wr(12'h018, 32'h0000_0000);
    wr(12'h01C, 32'h0000_0003);
    rd("freq on", 12'h044, 32'h0000_0001, 32'h0000_0001);
    wr(12'h01C, 32'h0000_0000);
    rd("freq off", 12'h044, 32'h0000_0001, 32'h0000_0000);
    $display("t_src done");
  endtask
  task automatic t_diff(input logic [31:0] fmt, input logic [3:0] exp);
    int n;
    logic [3:0] seen;
    wr(12'h000, fmt);
    for (n = 0; n < 500 && diff_output_on !== exp; n++) @(posedge clock);
    check("diff on", {28'h0, exp}, {28'h0, diff_output_on});
    // Output 3 rides the powered-down secondary APLL here, so it stays low
    seen = 4'h0;
    repeat (32)
    begin
      @(posedge clock);
      seen = seen | diff_output;
    end
    check("diff seen", {28'h0, exp & 4'h7}, {28'h0, seen});
    $display("t_diff done");
  endtask
  // Offset moves phase only, so edge counts hold after it is written
  task automatic t_fb(input int p_exp, input int s_exp);
    int p, s;
    logic lp, ls;
    p = 0;
    s = 0;
    wr(12'h040, 32'h4000_0000);
    repeat (4) @(posedge clock);
    lp = primary_feedback_clk;
    ls = secondary_feedback_clk;
    repeat (160)
    begin
      @(posedge clock);
      if (primary_feedback_clk === 1'b1 && lp === 1'b0) p++;
      if (secondary_feedback_clk === 1'b1 && ls === 1'b0) s++;
      lp = primary_feedback_clk;
      ls = secondary_feedback_clk;
    end
    check("pri fb edges", p_exp, p);
    check("sec fb edges", s_exp, s);
    $display("t_fb done");
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    wr(12'h010, 32'h0000_0400);
    t_sync(1'b0, 4, 2500);
    t_sync(1'b1, 1, 10000);
    // Both polarity bits set: the pulses become low-going
    wr(12'h010, 32'h0003_0400);
    inv = 1'b1;
    t_sync(1'b0, 4, 2500);
    t_sync(1'b1, 1, 10000);
    t_src();
    t_diff(32'h0000_0009, 4'b0011);
    t_diff(32'h0000_00A4, 4'b1110);
    t_diff(32'h0000_0000, 4'b0000);
    t_fb(20, 10);
    slow <= 1'b1;
    t_fb(10, 10);
    final_report();
  end
endmodule
bind output_clock_synth_routing output_clock_synth_routing_sva chk
(
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .general_output(general_output),
  .diff_output(diff_output), .diff_output_on(diff_output_on),
  .frame_sync_out(frame_sync_out), .multiframe_sync_out(multiframe_sync_out),
  .secondary_apll_power_on(secondary_apll_power_on)
);
`default_nettype wire

// >>> verif/output_clock_synth_routing_sva.sv
// Checker: port-level assertions for the output clock synthesis block
`timescale 1ns/1ps
`default_nettype none
module output_clock_synth_routing_sva
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] general_output,
  input wire logic [3:0] diff_output,
  input wire logic [3:0] diff_output_on,
  input wire logic frame_sync_out,
  input wire logic multiframe_sync_out,
  input wire logic secondary_apll_power_on
);
  // First pulse after reset lands one cycle past the steady period
  localparam int FS_GAP = 2501;
  localparam int MFS_GAP = 10001;
  logic [13:0] fs_gap_reg;
  logic [13:0] mfs_gap_reg;
  logic fs_last_reg;
  logic mfs_last_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // --------------------------------
  // Cycles since each sync line last moved
  // --------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fs_last_reg <= 1'b0;
      mfs_last_reg <= 1'b0;
      fs_gap_reg <= 14'h0000;
      mfs_gap_reg <= 14'h0000;
    end
    else
    begin
      fs_last_reg <= frame_sync_out;
      mfs_last_reg <= multiframe_sync_out;
      fs_gap_reg <= (frame_sync_out != fs_last_reg) ? 14'h0000
        : fs_gap_reg + 14'h0001;
      mfs_gap_reg <= (multiframe_sync_out != mfs_last_reg) ? 14'h0000
        : mfs_gap_reg + 14'h0001;
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held past one cycle");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside an access phase");
  property p_ready_latency;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_latency: assert property (p_ready_latency)
    else $error("pready late");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_diff_off;
    (diff_output & ~diff_output_on) == 4'h0;
  endproperty
  a_diff_off: assert property (p_diff_off)
    else $error("disabled differential output not low");
  property p_apll_off;
    !secondary_apll_power_on |-> !general_output[6];
  endproperty
  a_apll_off: assert property (p_apll_off)
    else $error("powered-down APLL output not low");
  property p_fs_gap;
    fs_gap_reg <= FS_GAP;
  endproperty
  a_fs_gap: assert property (p_fs_gap)
    else $error("frame sync period too long");
  property p_mfs_gap;
    mfs_gap_reg <= MFS_GAP;
  endproperty
  a_mfs_gap: assert property (p_mfs_gap)
    else $error("multiframe sync period too long");
endmodule
`default_nettype wire
